/* logic/rsr_pkg.sv */
// constants and types shared by the special register bank
package rsr_pkg;
   // ==========================================================
   // queue geometry
   localparam int RSR_WORD_W = 32;
   localparam int RSR_IN_DEPTH = 32;
   localparam int RSR_IN_AW = 5;
   localparam int RSR_OUT_DEPTH = 8;
   localparam int RSR_OUT_AW = 3;
   localparam logic [3:0] RSR_OUT_FULL_THR = 4'h6;
   localparam logic [3:0] RSR_OUT_HARD_FULL = 4'h8;
   localparam logic [5:0] RSR_IN_FULL = 6'h20;
   // ==========================================================
   // flag register fields
   localparam int RSR_FLG_HOST_IRQ = 0;
   localparam int RSR_FLG_BUSY = 1;
   localparam int RSR_FLG_OUT_NF = 2;
   localparam int RSR_FLG_ICBYP = 3;
   localparam int RSR_FLG_STAT_LO = 4;
   localparam int RSR_FLG_HSTAT_LO = 8;
   localparam int RSR_FLG_PICKV = 16;
   localparam int RSR_FLG_PICKH = 17;
   localparam int RSR_FLG_FORCE = 30;
   localparam int RSR_FLG_IN_NE = 31;
   localparam logic RSR_ICBYP_RST = 1'b1;
   localparam logic RSR_FORCE_RST = 1'b0;
   localparam int RSR_HOST_DELAY = 3;
   // ==========================================================
   // segment register and indirect addressing
   localparam int RSR_SEG_PTRS = 4;
   localparam int RSR_SEG_FIELD = 4;
   localparam int RSR_SEG_IDX_LO = 19;
   localparam int RSR_SEED_IDX_W = 13;
   localparam logic [1:0] RSR_INDIRECT_TAG = 2'h1;
   // ==========================================================
   // clip history, scale
   localparam int RSR_CLIP_LO = 2;
   localparam int RSR_CLIP_W = 6;
   localparam int RSR_SCALE_W = 6;
   // ==========================================================
   // polled interrupt register
   localparam int RSR_INT_N = 6;
   localparam int RSR_INT_LAST_ODD = 14;
   localparam int RSR_INT_LAST_B = 15;
   localparam int RSR_INT_EN_LO = 16;
   localparam int RSR_INT_ANY = 31;
   // ==========================================================
   // special register selects seen by the pipeline
   typedef enum logic [2:0] {
      RSR_FLAG,
      RSR_SEG,
      RSR_CLIP,
      RSR_SCALE,
      RSR_SEED,
      RSR_INTR,
      RSR_FIFO,
      RSR_SWFIFO
   } rsr_sel_t;
endpackage : rsr_pkg

/* logic/rsr_fifo.sv */
// word queue with a memory array, pointers and an occupancy count
`timescale 1ns/1ns
`default_nettype none
module rsr_fifo #(
   parameter int W = 32,
   parameter int D = 8,
   parameter int AW = 3
) (
   input wire logic clk_in, // core clock
   input wire logic rst_in, // synchronous reset
   input wire logic push_in, // write one word, caller checks room
   input wire logic [W-1:0] din_in, // word to write
   input wire logic pop_in, // drop head, caller checks occupancy
   output logic [W-1:0] head_out, // oldest word
   output logic [AW:0] cnt_out // words held
);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;

   // ==========================================================
   // storage, no reset needed on the array
   always_ff @(posedge clk_in) begin
      if (push_in) begin
         mem[wr_q] <= din_in;
      end
   end

   // depth is a power of two so pointers wrap on their own
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_q + AW'(push_in);
         rd_q <= rd_q + AW'(pop_in);
         cnt_q <= cnt_q + (AW+1)'(push_in) - (AW+1)'(pop_in);
      end
   end

   assign head_out = mem[rd_q];
   assign cnt_out = cnt_q;
endmodule : rsr_fifo
`default_nettype wire

/* logic/rsr_bank.sv */
// special hardware registers of the graphics core: queues, flags, segment, clip, seed, polling
//
// Contract
// - unused bits read zero, software writes zero
// - 32-word input queue, 8-word output queue
// - swapped alias exchanges bytes 3-0 and 2-1
// - vector use pops once; swap even only
// - stall on empty input or full output
// - output full seen at six, in decode
// - flag 30 override stops the six-entry output stall; eight entries still stall
// - flag 0 sticky host interrupt, host clears
// - busy and pick bits read-only in flags
// - flag 2 out-not-full, 31 in-not-empty
// - flag 3 forces cache miss, reset set
// - status 7:4 to host, 11:8 from host
// - four 3-bit pointers, nibble msb reads one
// - index 01xxxxxx maps to 128|ptr*16|low
// - clip flags shift in at bit 2
// - scale is msb position plus one
// - seed index in segment 31:19, seed word
// - pending bits sticky, cleared by writing one
// - external edge pending, polarity selectable
// - last-odd and last-b read-only indicators
// - enables 21:16, bit 31 any enabled
`timescale 1ns/1ns
`default_nettype none
module rsr_bank (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // synchronous reset, high
   input wire logic rd_en_in, // decode reads a special register
   input wire rsr_pkg::rsr_sel_t rd_sel_in, // which one
   input wire logic rd_vec_in, // read feeds a vector operation
   input wire logic wr_en_in, // same instruction writes a special register
   input wire rsr_pkg::rsr_sel_t wr_sel_in, // which one
   input wire logic [31:0] wr_data_in, // write data
   input wire logic [7:0] opidx_in, // operand index to resolve
   output logic [7:0] resolved_idx_out, // register file location
   output logic [31:0] rd_even_out, // read data, even operand
   output logic [31:0] rd_odd_out, // read data, odd operand
   output logic rd_valid_out, // read data valid pulse
   output logic stall_out, // last instruction refused, hold it
   output logic instruction_cache_bypass, // forces cache miss
   input wire logic in_push_in, // host pushes input word
   input wire logic [31:0] in_data_in, // host word
   output logic in_ready_out, // input queue has room
   input wire logic out_pop_in, // host takes output word
   output logic out_avail_out, // output queue holds a word
   output logic [31:0] out_data_out, // popped output word
   output logic out_strobe_out, // out_data_out fresh pulse
   input wire logic host_irq_clear_in, // host mailbox clear pulse
   output logic host_interrupt_request, // delayed flag bit 0
   output logic [3:0] core_to_host_status, // delayed flag 7:4
   input wire logic [3:0] host_to_core_status, // written by host
   input wire logic engines_busy, // any drawing engine busy
   input wire logic pick_mode_valid, // last pick setting
   input wire logic pick_draw_hit, // draw hit seen
   input wire logic clip_scalar_in, // one clip flag
   input wire logic clip_vector_in, // two clip flags
   input wire logic sort_in, // four identical flags
   input wire logic [1:0] clip_flag_in, // [1] even pair, [0] odd pair
   input wire logic seed_op_in, // seed operation
   input wire logic [31:0] seed_in, // seed operand
   input wire logic [31:0] seed_table_in, // table word for seed index
   output logic [12:0] seed_index_out, // normalized table index
   input wire logic retrace_ev_in, // start of vertical retrace
   input wire logic ext_irq_in, // external interrupt pin
   input wire logic expansion_bus_control, // 1 rising, 0 falling edge
   input wire logic video_even_ev_in, // even field ended
   input wire logic video_odd_ev_in, // odd field ended
   input wire logic watch_a_ev_in, // watched byte a written
   input wire logic watch_b_ev_in // watched byte b written
);
   import rsr_pkg::*;

   // ==========================================================
   // queues
   logic [31:0] in_head;
   logic [RSR_IN_AW:0] in_cnt;
   logic [31:0] out_head;
   logic [RSR_OUT_AW:0] out_cnt;
   logic rd_fifo;
   logic wr_fifo;
   logic in_empty;
   logic out_thr_full;
   logic flag_force_q;
   logic out_block;
   logic go;
   logic rd_do;
   logic wr_do;
   logic in_push;
   logic out_pop;
   logic [RSR_IN_AW:0] in_cnt_nx;
   logic [RSR_OUT_AW:0] out_cnt_nx;

   assign rd_fifo = rd_en_in && (rd_sel_in == RSR_FIFO || rd_sel_in == RSR_SWFIFO);
   assign wr_fifo = wr_en_in && wr_sel_in == RSR_FIFO;
   assign in_empty = in_cnt == '0;
   assign out_thr_full = out_cnt >= RSR_OUT_FULL_THR;
   // a real full queue blocks even under override, else a word would be lost
   assign out_block = (out_thr_full && !flag_force_q) || out_cnt == RSR_OUT_HARD_FULL;
   assign go = !(rd_fifo && in_empty) && !(wr_fifo && out_block);
   assign rd_do = rd_en_in && go;
   assign wr_do = wr_en_in && go;
   assign in_push = in_push_in && in_ready_out;
   assign out_pop = out_pop_in && out_avail_out;
   assign in_cnt_nx = in_cnt + (RSR_IN_AW+1)'(in_push) - (RSR_IN_AW+1)'(rd_do && rd_fifo);
   assign out_cnt_nx = out_cnt + (RSR_OUT_AW+1)'(wr_do && wr_fifo) - (RSR_OUT_AW+1)'(out_pop);

   // one pop per read, even for a vector source
   rsr_fifo #(.W(RSR_WORD_W), .D(RSR_IN_DEPTH), .AW(RSR_IN_AW)) u_in_q (
      .clk_in(core_clk_in),
      .rst_in(rst_in),
      .push_in(in_push),
      .din_in(in_data_in),
      .pop_in(rd_do && rd_fifo),
      .head_out(in_head),
      .cnt_out(in_cnt)
   );

   rsr_fifo #(.W(RSR_WORD_W), .D(RSR_OUT_DEPTH), .AW(RSR_OUT_AW)) u_out_q (
      .clk_in(core_clk_in),
      .rst_in(rst_in),
      .push_in(wr_do && wr_fifo),
      .din_in(wr_data_in),
      .pop_in(out_pop),
      .head_out(out_head),
      .cnt_out(out_cnt)
   );

   // ==========================================================
   // flag register
   logic flag_hirq_q;
   logic flag_icbyp_q;
   logic [3:0] flag_stat_q;
   logic wr_flag;
   logic hirq_d;
   logic [31:0] flag_word;
   logic [4:0] host_dly_q [RSR_HOST_DELAY];

   assign wr_flag = wr_do && wr_sel_in == RSR_FLAG;
   // a core set in the clear cycle wins; writing zero does nothing
   assign hirq_d = (wr_flag && wr_data_in[RSR_FLG_HOST_IRQ])
      || (flag_hirq_q && !host_irq_clear_in);
   assign flag_word = {!in_empty, flag_force_q, 12'h000, pick_draw_hit, pick_mode_valid,
      4'h0, host_to_core_status, flag_stat_q, flag_icbyp_q, !out_thr_full,
      engines_busy, flag_hirq_q};

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         flag_hirq_q <= 1'b0;
         flag_icbyp_q <= RSR_ICBYP_RST;
         flag_stat_q <= 4'h0;
         flag_force_q <= RSR_FORCE_RST;
      end else begin
         flag_hirq_q <= hirq_d;
         if (wr_flag) begin
            flag_icbyp_q <= wr_data_in[RSR_FLG_ICBYP];
            flag_stat_q <= wr_data_in[RSR_FLG_STAT_LO +: 4];
            flag_force_q <= wr_data_in[RSR_FLG_FORCE];
         end
      end
   end

   // host sees interrupt and status three cycles after the flag changes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < RSR_HOST_DELAY; i++) begin
            host_dly_q[i] <= 5'h00;
         end
      end else begin
         host_dly_q[0] <= {flag_stat_q, flag_hirq_q};
         for (int i = 1; i < RSR_HOST_DELAY; i++) begin
            host_dly_q[i] <= host_dly_q[i-1];
         end
      end
   end

   // ==========================================================
   // segment pointers and indirect index
   logic [2:0] seg_ptr_q [RSR_SEG_PTRS];
   logic [15:0] seg_lo;
   logic [RSR_SEED_IDX_W-1:0] seg_idx_q;
   logic [31:0] seg_word;
   logic wr_seg;
   logic [7:0] idx_d;

   assign wr_seg = wr_do && wr_sel_in == RSR_SEG;

   genvar g;
   generate
      for (g = 0; g < RSR_SEG_PTRS; g++) begin : g_seg
         assign seg_lo[g*RSR_SEG_FIELD +: RSR_SEG_FIELD] = {1'b1, seg_ptr_q[g]};
         always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
               seg_ptr_q[g] <= 3'h0;
            end else if (wr_seg) begin
               seg_ptr_q[g] <= wr_data_in[g*RSR_SEG_FIELD +: 3];
            end
         end
      end
   endgenerate

   assign seg_word = {seg_idx_q, 3'h0, seg_lo};
   // pointer writes take effect at once; software keeps the three-cycle gap
   assign idx_d = (opidx_in[7:6] == RSR_INDIRECT_TAG)
      ? {1'b1, seg_ptr_q[opidx_in[5:4]], opidx_in[3:0]} : opidx_in;

   // ==========================================================
   // clip history
   logic [RSR_CLIP_W-1:0] clip_q;
   logic [RSR_CLIP_W-1:0] clip_d;

   // even pair compared first, so its flag is the older one
   assign clip_d = sort_in ? {clip_q[1:0], {4{clip_flag_in[0]}}}
      : clip_vector_in ? {clip_q[3:0], clip_flag_in[1], clip_flag_in[0]}
      : clip_scalar_in ? {clip_q[4:0], clip_flag_in[0]} : clip_q;

   // ==========================================================
   // scale and seed
   logic [RSR_SCALE_W-1:0] scale_q;
   logic [RSR_SCALE_W-1:0] scale_d;
   logic [31:0] seed_norm;
   logic [31:0] seed_q;
   logic seed_pend_q;

   function automatic logic [RSR_SCALE_W-1:0] rsr_msb_pos(input logic [31:0] v);
      logic [RSR_SCALE_W-1:0] p;
      p = '0;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            p = RSR_SCALE_W'(i + 1);
         end
      end
      return p;
   endfunction : rsr_msb_pos

   assign scale_d = rsr_msb_pos(seed_in);
   assign seed_norm = (scale_d == '0) ? 32'h0000_0000 : seed_in << (6'h20 - scale_d);

   // ==========================================================
   // polled interrupt register
   logic [RSR_INT_N-1:0] pend_q;
   logic [RSR_INT_N-1:0] en_q;
   logic [RSR_INT_N-1:0] ev;
   logic [RSR_INT_N-1:0] clr;
   logic last_odd_q;
   logic last_b_q;
   logic ext_q;
   logic ext_edge;
   logic wr_intr;
   logic any_irq;
   logic [31:0] intr_word;

   // pin is synchronous to the core clock, one sample suffices
   assign ext_edge = expansion_bus_control ? (ext_irq_in && !ext_q)
      : (!ext_irq_in && ext_q);
   assign ev = {watch_b_ev_in, watch_a_ev_in, video_odd_ev_in, video_even_ev_in,
      ext_edge, retrace_ev_in};
   assign wr_intr = wr_do && wr_sel_in == RSR_INTR;
   assign clr = wr_intr ? wr_data_in[RSR_INT_N-1:0] : '0;
   assign any_irq = |(pend_q & en_q);
   assign intr_word = {any_irq, 9'h000, en_q, last_b_q, last_odd_q, 8'h00, pend_q};

   // ==========================================================
   // state updates for clip, seed and interrupts
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         clip_q <= '0;
         scale_q <= '0;
         seg_idx_q <= '0;
         seed_q <= 32'h0000_0000;
         seed_pend_q <= 1'b0;
         pend_q <= '0;
         en_q <= '0;
         last_odd_q <= 1'b0;
         last_b_q <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         clip_q <= clip_d;
         seed_pend_q <= seed_op_in;
         if (seed_op_in) begin
            scale_q <= scale_d;
            seg_idx_q <= seed_norm[31 -: RSR_SEED_IDX_W];
         end
         if (seed_pend_q) begin
            seed_q <= seed_table_in;
         end
         pend_q <= (pend_q & ~clr) | ev;
         if (wr_intr) begin
            en_q <= wr_data_in[RSR_INT_EN_LO +: RSR_INT_N];
         end
         if (video_odd_ev_in || video_even_ev_in) begin
            last_odd_q <= video_odd_ev_in;
         end
         if (watch_a_ev_in || watch_b_ev_in) begin
            last_b_q <= watch_b_ev_in;
         end
         ext_q <= ext_irq_in;
      end
   end

   // ==========================================================
   // read mux and registered outputs
   logic [31:0] reg_word;
   logic [31:0] swapped;
   logic [31:0] even_d;
   logic [31:0] odd_d;

   assign swapped = {in_head[7:0], in_head[15:8], in_head[23:16], in_head[31:24]};
   assign reg_word = (rd_sel_in == RSR_FLAG) ? flag_word
      : (rd_sel_in == RSR_SEG) ? seg_word
      : (rd_sel_in == RSR_CLIP) ? {24'h000000, clip_q, 2'h0}
      : (rd_sel_in == RSR_SCALE) ? {26'h0000000, scale_q}
      : (rd_sel_in == RSR_SEED) ? seed_q
      : (rd_sel_in == RSR_INTR) ? intr_word : in_head;
   assign even_d = (rd_sel_in == RSR_SWFIFO) ? swapped : reg_word;
   // only a vector source splits the alias; scalar use gets one word twice
   assign odd_d = (rd_sel_in == RSR_SWFIFO && !rd_vec_in) ? swapped : reg_word;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rd_even_out <= 32'h0000_0000;
         rd_odd_out <= 32'h0000_0000;
         rd_valid_out <= 1'b0;
         stall_out <= 1'b0;
         resolved_idx_out <= 8'h00;
         in_ready_out <= 1'b0;
         out_avail_out <= 1'b0;
         out_data_out <= 32'h0000_0000;
         out_strobe_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_do;
         if (rd_do) begin
            rd_even_out <= even_d;
            rd_odd_out <= odd_d;
         end
         stall_out <= (rd_en_in || wr_en_in) && !go;
         resolved_idx_out <= idx_d;
         in_ready_out <= in_cnt_nx != RSR_IN_FULL;
         out_avail_out <= out_cnt_nx != '0;
         out_strobe_out <= out_pop;
         if (out_pop) begin
            out_data_out <= out_head;
         end
      end
   end

   assign instruction_cache_bypass = flag_icbyp_q;
   assign host_interrupt_request = host_dly_q[RSR_HOST_DELAY-1][0];
   assign core_to_host_status = host_dly_q[RSR_HOST_DELAY-1][4:1];
   assign seed_index_out = seg_idx_q;

   // ==========================================================
   // checks
   a_pop_nonempty: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (rd_en_in && rd_fifo && in_cnt == '0) |=> stall_out && !rd_valid_out)
      else $error("read of empty input queue not stalled");

   a_out_thresh: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (wr_fifo && out_cnt == RSR_OUT_FULL_THR && !flag_force_q) |=> stall_out)
      else $error("write at six entries not stalled");

   a_force_pass: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (wr_fifo && !rd_fifo && flag_force_q && out_cnt < RSR_OUT_HARD_FULL) |=> !stall_out)
      else $error("override did not prevent output stall");

   a_host_delay: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ##3 (host_interrupt_request == $past(flag_hirq_q, 3)))
      else $error("host interrupt not delayed by three");

   a_pend_hold: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (pend_q[0] && !(wr_intr && wr_data_in[0])) |=> pend_q[0])
      else $error("pending retrace dropped without clear");

   a_swap_vec: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (rd_do && rd_sel_in == RSR_SWFIFO && rd_vec_in) |=>
      rd_even_out == {rd_odd_out[7:0], rd_odd_out[15:8], rd_odd_out[23:16],
      rd_odd_out[31:24]})
      else $error("swapped alias vector data mismatch");

   a_seg_ones: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (rd_do && rd_sel_in == RSR_SEG) |=> (rd_even_out & 32'h0000_8888) == 32'h0000_8888)
      else $error("segment nibble top bits not one");

   a_indirect_map: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (opidx_in[7:6] == 2'h1) |=> resolved_idx_out[7] && resolved_idx_out[3:0] ==
      $past(opidx_in[3:0]))
      else $error("indirect index mapped wrongly");

   a_any_irq: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ((ev & en_q) != '0 && !wr_intr) |=> intr_word[RSR_INT_ANY])
      else $error("enabled event did not raise summary bit");

   a_clip_shift: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (clip_scalar_in && !clip_vector_in && !sort_in) |=>
      clip_q == {$past(clip_q[4:0]), $past(clip_flag_in[0])})
      else $error("clip flag did not shift in at bit 2");

   a_scale_eight: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (seed_op_in && seed_in == 32'h0000_0008) |=> scale_q == 6'h04)
      else $error("scale of eight is not four");
endmodule : rsr_bank
`default_nettype wire

/* tb/rsr_host_model.sv */
// host-side model: fills the input queue and drains the output queue
`timescale 1ns/1ns
`default_nettype none
module rsr_host_model (
   input wire logic clk_in, // core clock
   input wire logic push_go_in, // keep pushing while there is room
   input wire logic pop_go_in, // keep popping while words wait
   input wire logic in_ready_in, // input queue has room
   input wire logic out_avail_in, // output queue holds a word
   input wire logic [31:0] out_data_in, // popped word
   input wire logic out_strobe_in, // popped word is fresh
   output logic in_push_out, // push strobe
   output logic [31:0] in_data_out, // pushed word
   output logic out_pop_out, // pop strobe
   output int pushed_out, // words accepted
   output int popped_out, // words received
   output logic [31:0] seen_out [8] // popped words in arrival order
);
   initial begin
      in_push_out = 1'b0;
      in_data_out = 32'h0;
      out_pop_out = 1'b0;
      pushed_out = 0;
      popped_out = 0;
   end
   // ==========================================================
   // strobes only while the block shows room or data, whole words
   always @(negedge clk_in) begin
      pushed_out <= pushed_out + int'(in_push_out);
      in_push_out <= push_go_in && in_ready_in;
      // a released data bus shows the inverse, not a stale word
      in_data_out <= (push_go_in && in_ready_in) ?
         (32'h1234_5600 | 32'(pushed_out + int'(in_push_out))) : ~in_data_out;
      out_pop_out <= pop_go_in && out_avail_in;
   end
   always @(posedge clk_in) begin
      if (out_strobe_in && popped_out < 8) begin
         seen_out[popped_out] <= out_data_in;
         popped_out <= popped_out + 1;
      end
   end
endmodule : rsr_host_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the special register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import rsr_pkg::*;
   logic clk = 0, rst = 1, rd_en = 0, rd_vec = 0, wr_en = 0, clr = 0, ext = 0, ebc = 1;
   logic pgo = 0, qgo = 0, cs = 0, cv = 0, srt = 0, sop = 0;
   logic ev_r = 0, ev_e = 0, ev_o = 0, ev_a = 0, ev_b = 0;
   logic bsy = 0, pkv = 0, pkh = 0;
   rsr_sel_t rs = RSR_FLAG;
   logic [31:0] wd = 0, seed = 0, tbl = 0, re, ro, ind, od;
   logic [7:0] idx = 0, ridx;
   logic [1:0] cf = 0;
   logic rv, stall, icb, rdy, avail, ostb, hirq, push, pop;
   logic [3:0] hst;
   logic [12:0] sidx;
   int miscompares = 0, n_compared = 0, pushed, popped;
   logic [31:0] seen [8];
   rsr_bank u_rsr_bank (.core_clk_in(clk), .rst_in(rst), .rd_en_in(rd_en), .rd_sel_in(rs),
      .rd_vec_in(rd_vec), .wr_en_in(wr_en), .wr_sel_in(rs), .wr_data_in(wd), .opidx_in(idx),
      .resolved_idx_out(ridx), .rd_even_out(re), .rd_odd_out(ro), .rd_valid_out(rv),
      .stall_out(stall), .instruction_cache_bypass(icb), .in_push_in(push), .in_data_in(ind),
      .in_ready_out(rdy), .out_pop_in(pop), .out_avail_out(avail), .out_data_out(od),
      .out_strobe_out(ostb), .host_irq_clear_in(clr), .host_interrupt_request(hirq),
      .core_to_host_status(hst), .host_to_core_status(4'ha), .engines_busy(bsy),
      .pick_mode_valid(pkv), .pick_draw_hit(pkh), .clip_scalar_in(cs), .clip_vector_in(cv),
      .sort_in(srt), .clip_flag_in(cf), .seed_op_in(sop), .seed_in(seed), .seed_table_in(tbl),
      .seed_index_out(sidx), .retrace_ev_in(ev_r), .ext_irq_in(ext),
      .expansion_bus_control(ebc), .video_even_ev_in(ev_e), .video_odd_ev_in(ev_o),
      .watch_a_ev_in(ev_a), .watch_b_ev_in(ev_b));
   rsr_host_model u_rsr_host_model (.clk_in(clk), .push_go_in(pgo), .pop_go_in(qgo),
      .in_ready_in(rdy), .out_avail_in(avail), .out_data_in(od), .out_strobe_in(ostb),
      .in_push_out(push), .in_data_out(ind), .out_pop_out(pop), .pushed_out(pushed),
      .popped_out(popped), .seen_out(seen));
   initial begin
      forever #2 clk = ~clk;
   end
   // ==========================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk
   // one instruction in decode for one cycle; results settle by the return
   task automatic op(input logic r, input logic w, input rsr_sel_t s, input logic v,
         input logic [31:0] d);
      @(negedge clk);
      rd_en = r;
      wr_en = w;
      rs = s;
      rd_vec = v;
      wd = d;
      @(negedge clk);
      rd_en = 0;
      wr_en = 0;
   endtask : op
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1;
      @(negedge clk);
      s = 0;
   endtask : pulse
   task automatic conclude();
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // ==========================================================
   // scenarios
   task automatic t_inq();
      logic [31:0] w, e;
      op(1, 0, RSR_FLAG, 0, 0);
      chk("flag_rst", 32'h0000_0a0c, re);
      chk("icb_rst", 1, icb);
      chk("valid", 1, rv);
      pgo = 1;
      repeat (40) @(negedge clk);
      pgo = 0;
      chk("pushed", 32, pushed);
      op(1, 0, RSR_FLAG, 0, 0);
      chk("flag_in", 32'h8000_0a0c, re);
      for (int i = 0; i < 32; i++) begin
         w = 32'h1234_5600 | 32'(i);
         e = (i % 2) ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
         op(1, 0, (i % 2) ? RSR_SWFIFO : RSR_FIFO, i % 4 == 1, 0);
         chk("even", e, re);
         chk("odd", (i % 4 == 1) ? w : e, ro);
      end
      op(1, 0, RSR_FIFO, 0, 0);
      chk("stall_empty", 1, stall);
      chk("valid_empty", 0, rv);
   endtask : t_inq
   task automatic t_outq();
      for (int i = 0; i < 6; i++) op(0, 1, RSR_FIFO, 0, 32'ha0 + 32'(i));
      op(1, 0, RSR_FLAG, 0, 0);
      chk("flag2", 0, re[2]);
      op(0, 1, RSR_FIFO, 0, 32'h77);
      chk("stall_six", 1, stall);
      op(0, 1, RSR_FLAG, 0, 32'h4000_0008);
      op(0, 1, RSR_FIFO, 0, 32'ha6);
      op(0, 1, RSR_FIFO, 0, 32'ha7);
      chk("stall_force", 0, stall);
      op(0, 1, RSR_FIFO, 0, 32'h77);
      chk("stall_eight", 1, stall);
      qgo = 1;
      repeat (20) @(negedge clk);
      qgo = 0;
      chk("popped", 8, popped);
      for (int i = 0; i < 8; i++) chk("order", 32'ha0 + 32'(i), seen[i]);
      op(0, 1, RSR_FLAG, 0, 32'h0000_0008);
   endtask : t_outq
   task automatic t_host();
      op(0, 1, RSR_FLAG, 0, 32'h0000_00a1);
      chk("irq_early", 0, hirq);
      repeat (2) @(negedge clk);
      chk("irq_early", 0, hirq);
      @(negedge clk);
      chk("irq", 1, hirq);
      chk("status", 4'ha, hst);
      chk("icb", 0, icb);
      op(0, 1, RSR_FLAG, 0, 32'h0);
      op(1, 0, RSR_FLAG, 0, 0);
      chk("flag0_held", 1, re[0]);
      pulse(clr);
      op(1, 0, RSR_FLAG, 0, 0);
      chk("flag_clr", 32'h0000_0a04, re);
      {bsy, pkv, pkh} = 3'h7;
      op(1, 0, RSR_FLAG, 0, 0);
      chk("flag_ro", 32'h0003_0a06, re);
      {bsy, pkv, pkh} = 3'h0;
   endtask : t_host
   task automatic t_misc();
      op(0, 1, RSR_SEG, 0, 32'h0000_7531);
      repeat (3) @(negedge clk); // pointer settle time
      idx = 8'h6a;
      @(negedge clk);
      chk("indirect", 8'hda, ridx);
      idx = 8'h85;
      @(negedge clk);
      chk("direct", 8'h85, ridx);
      op(1, 0, RSR_SEG, 0, 0);
      chk("seg", 32'h0000_fdb9, re);
      tbl = 32'hc0de_0000;
      seed = 8;
      pulse(sop);
      op(1, 0, RSR_SCALE, 0, 0);
      chk("scale", 4, re);
      op(1, 0, RSR_SEED, 0, 0);
      chk("seed", 32'hc0de_0000, re);
      chk("seed_idx", 32'h0000_1000, sidx);
      seed = 0;
      pulse(sop);
      op(1, 0, RSR_SCALE, 0, 0);
      chk("scale0", 0, re);
      cf = 2'b01;
      pulse(cs);
      cf = 2'b10;
      pulse(cv);
      cf = 2'b11;
      pulse(srt);
      op(1, 0, RSR_CLIP, 0, 0);
      chk("clip", 32'hbc, re);
   endtask : t_misc
   task automatic t_intr();
      pulse(ev_r);
      pulse(ext);
      pulse(ev_e);
      pulse(ev_o);
      pulse(ev_a);
      pulse(ev_b);
      op(1, 0, RSR_INTR, 0, 0);
      chk("intr", 32'h0000_c03f, re);
      op(0, 1, RSR_INTR, 0, 32'h0001_0000);
      op(1, 0, RSR_INTR, 0, 0);
      chk("intr_en", 32'h8001_c03f, re);
      ebc = 0;
      op(0, 1, RSR_INTR, 0, 32'h0003_0003);
      op(1, 0, RSR_INTR, 0, 0);
      chk("intr_clr", 32'h0003_c03c, re);
      pulse(ext);
      op(1, 0, RSR_INTR, 0, 0);
      chk("intr_fall", 32'h8003_c03e, re);
   endtask : t_intr
   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      t_inq();
      t_outq();
      t_host();
      t_misc();
      t_intr();
      conclude();
   end
   initial begin
      #100000;
      miscompares++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
